//--- logic/cpm_pkg.sv
// shared constants and types of the clock and power mode control block
package cpm_pkg;
    // register byte addresses on the avalon bus
    localparam logic [31:0] PowerKeyFirstAddr  = 32'hffff0404;
    localparam logic [31:0] PowerCtrlAddr      = 32'hffff0408;
    localparam logic [31:0] PowerKeySecondAddr = 32'hffff040c;
    localparam logic [31:0] ClockKeyFirstAddr  = 32'hffff0410;
    localparam logic [31:0] ClockModeAddr      = 32'hffff0414;
    localparam logic [31:0] ClockKeySecondAddr = 32'hffff0418;
    localparam logic [31:0] StatusAddr         = 32'hffff041c;

    // unlock key values
    localparam logic [15:0] PowerKeyFirstVal  = 16'h0001;
    localparam logic [15:0] PowerKeySecondVal = 16'h00f4;
    localparam logic [15:0] ClockKeyFirstVal  = 16'h00aa;
    localparam logic [15:0] ClockKeySecondVal = 16'h0055;

    // reset values
    localparam logic [7:0]  ClockModeReset = 8'h21;
    localparam logic [7:0]  PowerCtrlReset = 8'h03;
    localparam logic [15:0] KeyReset       = 16'h0000;

    // field positions
    localparam int RefOscBit     = 5;
    localparam int ClockModeLsb  = 0;
    localparam int PowerStateLsb = 4;
    localparam int DividerLsb    = 0;
    localparam int StatusHaltBit = 0;
    localparam int StatusExtBit  = 1;

    // clock mode codes
    localparam logic [1:0] ModePll    = 2'h1;
    localparam logic [1:0] ModeExtPin = 2'h3;

    // power state codes
    localparam logic [2:0] StateActive = 3'h0;
    localparam logic [2:0] StatePause  = 3'h1;
    localparam logic [2:0] StateNap    = 3'h2;
    localparam logic [2:0] StateSleep  = 3'h3;
    localparam logic [2:0] StateStop   = 3'h4;

    // divider: code n divides by 2**n, largest ratio 128
    localparam int DivCountWidth = 7;

    // one key-guarded register's access strobes, valid at the completing bus edge
    typedef struct packed {
        logic        firstWr;
        logic        targetWr;
        logic        secondWr;
        logic [15:0] data;
    } cpm_key_seq_type;
endpackage

//--- logic/cpm_key_guard.sv
// unlock sequencer: first key, target write, second key, then commit
`timescale 1ns/10ps
module cpm_key_guard #(
    parameter logic [15:0] FirstKey  = 16'h0000,
    parameter logic [15:0] SecondKey = 16'h0000
) (
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire cpm_pkg::cpm_key_seq_type seq,
    output logic                          commit,
    output logic [7:0]                    stagedValue
);
    typedef enum logic [1:0] {Idle, Armed, Staged} cpm_guard_state_type;

    cpm_guard_state_type state_reg;
    cpm_guard_state_type state_next;
    logic                commit_reg;
    logic                commit_next;
    logic [7:0]          staged_reg;
    logic [7:0]          staged_next;

    always_comb
    begin
        state_next  = state_reg;
        commit_next = 1'b0;
        staged_next = staged_reg;
        case (state_reg)
            Idle:
            begin
                if (seq.firstWr && seq.data == FirstKey)
                    state_next = Armed;
            end
            Armed:
            begin
                // a second key without a staged value leaves the register alone
                if (seq.targetWr)
                begin
                    state_next  = Staged;
                    staged_next = seq.data[7:0];
                end
                else if (seq.firstWr)
                    state_next = (seq.data == FirstKey) ? Armed : Idle;
                else if (seq.secondWr)
                    state_next = Idle;
            end
            Staged:
            begin
                if (seq.secondWr)
                begin
                    state_next  = Idle;
                    commit_next = (seq.data == SecondKey);
                end
                else if (seq.firstWr)
                    state_next = (seq.data == FirstKey) ? Armed : Idle;
                else if (seq.targetWr)
                    state_next = Idle;
            end
            default: state_next = Idle;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_reg  <= Idle;
            commit_reg <= 1'b0;
            staged_reg <= 8'h00;
        end
        else
        begin
            state_reg  <= state_next;
            commit_reg <= commit_next;
            staged_reg <= staged_next;
        end
    end

    assign commit      = commit_reg;
    assign stagedValue = staged_reg;

    guard_commit_cause_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        commit_reg |-> $past(state_reg == Staged && seq.secondWr && seq.data == SecondKey))
        else $error("commit without full key sequence");
endmodule

//--- logic/cpm_core_divider.sv
// power-of-two core clock divider producing a one-cycle core tick
`timescale 1ns/10ps
module cpm_core_divider (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] divCode,
    input  wire logic       halted,
    output logic            coreTick
);
    logic [cpm_pkg::DivCountWidth-1:0] count_reg;
    logic [cpm_pkg::DivCountWidth-1:0] count_next;
    logic [cpm_pkg::DivCountWidth-1:0] limit;
    logic                              tick_reg;
    logic                              tick_next;

    always_comb
    begin
        limit      = cpm_pkg::DivCountWidth'((8'h01 << divCode) - 8'h01);
        count_next = count_reg;
        tick_next  = 1'b0;
        // ticks stop while halted; counting restarts from zero on wake
        if (halted)
            count_next = '0;
        else if (count_reg >= limit)
        begin
            count_next = '0;
            tick_next  = 1'b1;
        end
        else
            count_next = count_reg + 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            count_reg <= '0;
            tick_reg  <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick_reg  <= tick_next;
        end
    end

    assign coreTick = tick_reg;

    divider_tick_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tick_reg |-> $past(count_reg) >= $past(limit) && !$past(halted))
        else $error("core tick before divider count ran out");
    divider_halt_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        halted [*2] |-> !tick_reg)
        else $error("core tick while halted");
endmodule

//--- logic/cpm_clock_power_ctrl.sv
// clock source, core divider and power state control with avalon-mm registers
// Behaviour
// - clock mode bit 5 picks reference: 1 internal oscillator, 0 crystal; resets 1.
// - clock mode bits 1:0: 01 runs from pll, 11 from external pin.
// - power bits 6:4: active, pause, nap, sleep, stop; other codes reserved.
// - in sleep, any external interrupt line or wake timer wakes the core.
// - in stop, only external interrupt lines wake; wake timer ignored.
// - core clock divided by two to the power of divider bits 2:0.
// - guarded registers change only after the full key unlock sequence; a wake sets power bits 6:4 to active without one.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
module cpm_clock_power_ctrl (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [31:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  extIrq,
    input  wire logic        wakeTimer,
    output logic             refOscInternal,
    output logic             clkSrcPll,
    output logic             clkSrcExtPin,
    output logic [2:0]       powerState,
    output logic             coreHalted,
    output logic             coreTick
);
    logic                     ack_reg;
    logic                     ack_next;
    logic [31:0]              readData_reg;
    logic [31:0]              readData_next;
    logic                     wrDone;
    logic [15:0]              wrData;
    cpm_pkg::cpm_key_seq_type powSeq;
    cpm_pkg::cpm_key_seq_type clkSeq;
    logic                     powCommit;
    logic                     clkCommit;
    logic [7:0]               powStaged;
    logic [7:0]               clkStaged;
    // declared up front: the bus read mux looks at them
    logic [7:0]               powerCtrl_reg;
    logic [7:0]               powerCtrl_next;
    logic [7:0]               clockMode_reg;
    logic [7:0]               clockMode_next;
    logic                     clkSrcExtPin_reg;
    logic                     coreHalted_reg;
    logic                     waitReq_reg;
    logic                     waitReq_next;

    // bus slave: answer one cycle after the request is seen
    always_comb
    begin
        ack_next      = (avs_read || avs_write) && !ack_reg;
        readData_next = readData_reg;
        // own flop so waitrequest leaves the block with no gate behind it
        waitReq_next  = !ack_next;
        if (avs_read && !ack_reg)
        begin
            case (avs_address)
                cpm_pkg::PowerCtrlAddr: readData_next = {24'h000000, powerCtrl_reg};
                cpm_pkg::ClockModeAddr: readData_next = {24'h000000, clockMode_reg};
                cpm_pkg::StatusAddr:
                begin
                    readData_next = 32'h00000000;
                    readData_next[cpm_pkg::StatusHaltBit] = coreHalted_reg;
                    readData_next[cpm_pkg::StatusExtBit]  = clkSrcExtPin_reg;
                end
                // key registers are write only and read as zero
                default: readData_next = {16'h0000, cpm_pkg::KeyReset};
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ack_reg      <= 1'b0;
            waitReq_reg  <= 1'b1;
            readData_reg <= 32'h00000000;
        end
        else
        begin
            ack_reg      <= ack_next;
            waitReq_reg  <= waitReq_next;
            readData_reg <= readData_next;
        end
    end

    // write strobes at the edge where the master sees waitrequest low
    always_comb
    begin
        wrDone          = avs_write && ack_reg && avs_byteenable[0];
        wrData          = avs_writedata[15:0];
        if (!avs_byteenable[1])
            wrData[15:8] = 8'h00;
        powSeq.firstWr  = wrDone && avs_address == cpm_pkg::PowerKeyFirstAddr;
        powSeq.targetWr = wrDone && avs_address == cpm_pkg::PowerCtrlAddr;
        powSeq.secondWr = wrDone && avs_address == cpm_pkg::PowerKeySecondAddr;
        powSeq.data     = wrData;
        clkSeq.firstWr  = wrDone && avs_address == cpm_pkg::ClockKeyFirstAddr;
        clkSeq.targetWr = wrDone && avs_address == cpm_pkg::ClockModeAddr;
        clkSeq.secondWr = wrDone && avs_address == cpm_pkg::ClockKeySecondAddr;
        clkSeq.data     = wrData;
    end

    cpm_key_guard #(
        .FirstKey  (cpm_pkg::PowerKeyFirstVal),
        .SecondKey (cpm_pkg::PowerKeySecondVal)
    ) powerGuard (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .seq         (powSeq),
        .commit      (powCommit),
        .stagedValue (powStaged)
    );

    cpm_key_guard #(
        .FirstKey  (cpm_pkg::ClockKeyFirstVal),
        .SecondKey (cpm_pkg::ClockKeySecondVal)
    ) clockGuard (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .seq         (clkSeq),
        .commit      (clkCommit),
        .stagedValue (clkStaged)
    );

    // guarded registers and power state
    logic [2:0] curState;
    logic [2:0] newState;
    logic [1:0] newMode;
    logic       wakeNow;
    logic       powValid;
    logic       clkValid;

    always_comb
    begin
        curState = powerCtrl_reg[cpm_pkg::PowerStateLsb +: 3];
        newState = powStaged[cpm_pkg::PowerStateLsb +: 3];
        newMode  = clkStaged[cpm_pkg::ClockModeLsb +: 2];
        powValid = newState <= cpm_pkg::StateStop;
        clkValid = newMode == cpm_pkg::ModePll || newMode == cpm_pkg::ModeExtPin;
        case (curState)
            cpm_pkg::StatePause: wakeNow = (|extIrq) || wakeTimer;
            cpm_pkg::StateNap:   wakeNow = (|extIrq) || wakeTimer;
            cpm_pkg::StateSleep: wakeNow = (|extIrq) || wakeTimer;
            cpm_pkg::StateStop:  wakeNow = |extIrq;
            default:             wakeNow = 1'b0;
        endcase
        powerCtrl_next = powerCtrl_reg;
        // a committed write wins over a wake in the same cycle
        if (powCommit && powValid)
        begin
            powerCtrl_next = 8'h00;
            powerCtrl_next[cpm_pkg::PowerStateLsb +: 3] = newState;
            powerCtrl_next[cpm_pkg::DividerLsb +: 3]    = powStaged[cpm_pkg::DividerLsb +: 3];
        end
        else if (wakeNow)
            powerCtrl_next[cpm_pkg::PowerStateLsb +: 3] = cpm_pkg::StateActive;
        clockMode_next = clockMode_reg;
        if (clkCommit && clkValid)
        begin
            clockMode_next = 8'h00;
            clockMode_next[cpm_pkg::RefOscBit]          = clkStaged[cpm_pkg::RefOscBit];
            clockMode_next[cpm_pkg::ClockModeLsb +: 2]  = newMode;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            powerCtrl_reg <= cpm_pkg::PowerCtrlReset;
            clockMode_reg <= cpm_pkg::ClockModeReset;
        end
        else
        begin
            powerCtrl_reg <= powerCtrl_next;
            clockMode_reg <= clockMode_next;
        end
    end

    // registered decode of the control fields
    logic       refOscInternal_reg;
    logic       clkSrcPll_reg;
    logic [2:0] powerState_reg;
    logic       refOscInternal_next;
    logic       clkSrcPll_next;
    logic       clkSrcExtPin_next;
    logic [2:0] powerState_next;
    logic       coreHalted_next;

    always_comb
    begin
        refOscInternal_next = clockMode_reg[cpm_pkg::RefOscBit];
        clkSrcPll_next      = clockMode_reg[cpm_pkg::ClockModeLsb +: 2] == cpm_pkg::ModePll;
        clkSrcExtPin_next   = clockMode_reg[cpm_pkg::ClockModeLsb +: 2] == cpm_pkg::ModeExtPin;
        powerState_next     = curState;
        coreHalted_next     = curState != cpm_pkg::StateActive;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            refOscInternal_reg <= 1'b1;
            clkSrcPll_reg      <= 1'b1;
            clkSrcExtPin_reg   <= 1'b0;
            powerState_reg     <= cpm_pkg::StateActive;
            coreHalted_reg     <= 1'b0;
        end
        else
        begin
            refOscInternal_reg <= refOscInternal_next;
            clkSrcPll_reg      <= clkSrcPll_next;
            clkSrcExtPin_reg   <= clkSrcExtPin_next;
            powerState_reg     <= powerState_next;
            coreHalted_reg     <= coreHalted_next;
        end
    end

    cpm_core_divider coreDivider (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .divCode  (powerCtrl_reg[cpm_pkg::DividerLsb +: 3]),
        .halted   (coreHalted_reg),
        .coreTick (coreTick)
    );

    assign avs_readdata    = readData_reg;
    assign avs_waitrequest = waitReq_reg;
    assign refOscInternal  = refOscInternal_reg;
    assign clkSrcPll       = clkSrcPll_reg;
    assign clkSrcExtPin    = clkSrcExtPin_reg;
    assign powerState      = powerState_reg;
    assign coreHalted      = coreHalted_reg;

    reset_values_a: assert property (@(posedge sys_clk)
        $fell(sys_rst) |-> powerCtrl_reg == 8'h03 && clockMode_reg == 8'h21)
        else $error("wrong register values after reset");
    refosc_follow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 refOscInternal == $past(clockMode_reg[5]))
        else $error("reference select output does not follow bit 5");
    clock_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 clkSrcExtPin == ($past(clockMode_reg[1:0]) == 2'h3)
            && clkSrcPll == ($past(clockMode_reg[1:0]) == 2'h1))
        else $error("clock source decode wrong");
    reserved_state_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        powCommit && powStaged[6:4] > 3'h4 && !wakeNow |=> $stable(powerCtrl_reg))
        else $error("reserved power state accepted");
    sleep_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        curState == 3'h3 && ((|extIrq) || wakeTimer) && !powCommit
            |=> curState == 3'h0 ##1 !coreHalted)
        else $error("sleep did not wake");
    stop_timer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        curState == 3'h4 && !(|extIrq) && wakeTimer && !powCommit |=> curState == 3'h4)
        else $error("wake timer woke stop state");
    guarded_change_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(sys_rst) && $changed(clockMode_reg) |-> $past(clkCommit))
        else $error("clock mode changed without unlock");
    bus_answer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");

    // register-level checks: they pin the decode, not only the outputs
    divider_guarded_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(sys_rst) && $changed(powerCtrl_reg[2:0]) |-> $past(powCommit))
        else $error("divider changed without unlock");
    stop_irq_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        curState == 3'h4 && (|extIrq) && !powCommit |=> curState == 3'h0)
        else $error("interrupt line did not wake stop state");
    key_read_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        avs_read && avs_waitrequest && (avs_address == 32'hffff0404
            || avs_address == 32'hffff040c) |=> avs_readdata == 32'h00000000)
        else $error("power key register read not zero");
    reserved_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clkCommit && clkStaged[1:0] != 2'h1 && clkStaged[1:0] != 2'h3 |=> $stable(clockMode_reg))
        else $error("reserved clock mode accepted");
    state_decode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 powerState == $past(curState) && coreHalted == ($past(curState) != 3'h0))
        else $error("power state outputs do not follow the field");
    power_commit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        powCommit && powValid |=> powerCtrl_reg[6:4] == $past(powStaged[6:4])
            && powerCtrl_reg[2:0] == $past(powStaged[2:0]))
        else $error("unlocked power value not taken");
    bus_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    light_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (curState == 3'h1 || curState == 3'h2) && ((|extIrq) || wakeTimer) && !powCommit
            |=> curState == 3'h0)
        else $error("pause or nap did not wake");
    wake_divider_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wakeNow && !powCommit |=> $stable(powerCtrl_reg[2:0]))
        else $error("wake changed the divider");
endmodule

//--- tb/testbench.sv
// self-checking bench of the clock and power mode control block
`timescale 1ns/10ps
module testbench;
    logic        sys_clk;
    logic        sys_rst;
    logic [31:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [3:0]  extIrq;
    logic        wakeTimer;
    logic        refOscInternal;
    logic        clkSrcPll;
    logic        clkSrcExtPin;
    logic [2:0]  powerState;
    logic        coreHalted;
    logic        coreTick;
    int          err_count;
    int          checked;
    int          seed;
    logic [31:0] expQ[$];

    cpm_clock_power_ctrl cpm_clock_power_ctrl_inst (
        .sys_clk         (sys_clk),
        .sys_rst         (sys_rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .extIrq          (extIrq),
        .wakeTimer       (wakeTimer),
        .refOscInternal  (refOscInternal),
        .clkSrcPll       (clkSrcPll),
        .clkSrcExtPin    (clkSrcExtPin),
        .powerState      (powerState),
        .coreHalted      (coreHalted),
        .coreTick        (coreTick)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        $display("mismatches %0d of %0d comparisons", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one avalon transfer; held until waitrequest is sampled low, released after that edge
    task automatic bus(input logic rd, input logic [31:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= addr;
        avs_writedata <= data;
        avs_read      <= rd;
        avs_write     <= ~rd;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            check("waitrequest", 32'h1, 32'h0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        expQ.push_back(exp);
        bus(1'b1, addr, 32'h0);
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        bus(1'b0, addr, data);
    endtask

    task automatic key_power(input logic [31:0] val);
        wr(cpm_pkg::PowerKeyFirstAddr, 32'(cpm_pkg::PowerKeyFirstVal));
        wr(cpm_pkg::PowerCtrlAddr, val);
        wr(cpm_pkg::PowerKeySecondAddr, 32'(cpm_pkg::PowerKeySecondVal));
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic key_clock(input logic [31:0] val);
        wr(cpm_pkg::ClockKeyFirstAddr, 32'(cpm_pkg::ClockKeyFirstVal));
        wr(cpm_pkg::ClockModeAddr, val);
        wr(cpm_pkg::ClockKeySecondAddr, 32'(cpm_pkg::ClockKeySecondVal));
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic outs(input logic osc, input logic pll, input logic ext, input logic [2:0] st);
        check("refOscInternal", 32'(refOscInternal), 32'(osc));
        check("clkSrcPll", 32'(clkSrcPll), 32'(pll));
        check("clkSrcExtPin", 32'(clkSrcExtPin), 32'(ext));
        check("powerState", 32'(powerState), 32'(st));
        check("coreHalted", 32'(coreHalted), 32'(st != 3'h0));
    endtask

    // tick spacing is measured between two pulses, so the start-up phase does not matter
    task automatic div_check(input logic [2:0] code);
        int n;
        int gap;
        n = 0;
        gap = 1;
        key_power({24'h0, 1'b0, cpm_pkg::StateActive, 1'b0, code});
        while (coreTick !== 1'b1 && n < 300)
        begin
            @(posedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        while (coreTick !== 1'b1 && gap < 300)
        begin
            @(posedge sys_clk);
            gap++;
        end
        check("coreTick gap", 32'(gap), 32'h1 << code);
    endtask

    // read answers are checked against the oldest note in the queue
    always @(posedge sys_clk)
    begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
        begin
            if (expQ.size() == 0)
                check("read queue", 32'h1, 32'h0);
            else
                check("avs_readdata", avs_readdata, expQ.pop_front());
        end
    end

    initial
    begin
        // over twenty times the longest expected run
        #300000;
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        logic [31:0] keyAddr[4];
        logic [2:0]  rsv;
        logic        woke;
        err_count = 0;
        checked = 0;
        seed = 78;
        sys_rst = 1'b1;
        avs_address = 32'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        extIrq = 4'h0;
        wakeTimer = 1'b0;
        keyAddr = '{cpm_pkg::PowerKeyFirstAddr, cpm_pkg::PowerKeySecondAddr,
                    cpm_pkg::ClockKeyFirstAddr, cpm_pkg::ClockKeySecondAddr};
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        outs(1'b1, 1'b1, 1'b0, 3'h0);
        rd(cpm_pkg::PowerCtrlAddr, 32'h03);
        rd(cpm_pkg::ClockModeAddr, 32'h21);
        foreach (keyAddr[i])
            rd(keyAddr[i], 32'h0);
        rd(32'hffff0500 + (32'($random(seed)) & 32'hfc), 32'h0);
        // stray, out-of-order and wrong-key writes must all leave the registers alone
        wr(cpm_pkg::PowerCtrlAddr, 32'h13);
        wr(cpm_pkg::PowerKeySecondAddr, 32'(cpm_pkg::PowerKeySecondVal));
        wr(cpm_pkg::PowerKeyFirstAddr, 32'h00f4);
        wr(cpm_pkg::PowerCtrlAddr, 32'h13);
        wr(cpm_pkg::PowerKeySecondAddr, 32'(cpm_pkg::PowerKeySecondVal));
        wr(cpm_pkg::ClockKeyFirstAddr, 32'(cpm_pkg::ClockKeyFirstVal));
        wr(cpm_pkg::ClockModeAddr, 32'h03);
        wr(cpm_pkg::ClockKeySecondAddr, 32'h00aa);
        repeat (3) @(posedge sys_clk);
        rd(cpm_pkg::PowerCtrlAddr, 32'h03);
        rd(cpm_pkg::ClockModeAddr, 32'h21);
        outs(1'b1, 1'b1, 1'b0, 3'h0);
        key_clock(32'h03);
        outs(1'b0, 1'b0, 1'b1, 3'h0);
        rd(cpm_pkg::ClockModeAddr, 32'h03);
        rd(cpm_pkg::StatusAddr, 32'h02);
        key_clock(32'h00);
        outs(1'b0, 1'b0, 1'b1, 3'h0);
        key_clock(32'h21);
        outs(1'b1, 1'b1, 1'b0, 3'h0);
        rsv = 3'h5 + 3'($unsigned($random(seed)) % 3);
        key_power({24'h0, 1'b0, rsv, 4'h3});
        outs(1'b1, 1'b1, 1'b0, 3'h0);
        // wake sources 0..3 are interrupt lines, 4 is the wake timer
        for (int s = 1; s <= 4; s++)
        begin
            for (int w = 0; w < 5; w++)
            begin
                key_power({24'h0, 1'b0, 3'(s), 4'h3});
                outs(1'b1, 1'b1, 1'b0, 3'(s));
                rd(cpm_pkg::PowerCtrlAddr, {24'h0, 1'b0, 3'(s), 4'h3});
                rd(cpm_pkg::StatusAddr, 32'h01);
                woke = !(s == 4 && w == 4);
                if (w == 4)
                    wakeTimer <= 1'b1;
                else
                    extIrq <= 4'h1 << w;
                repeat (4) @(posedge sys_clk);
                outs(1'b1, 1'b1, 1'b0, woke ? 3'h0 : 3'(s));
                wakeTimer <= 1'b0;
                extIrq <= woke ? 4'h0 : 4'h8;
                repeat (4) @(posedge sys_clk);
                extIrq <= 4'h0;
                outs(1'b1, 1'b1, 1'b0, 3'h0);
            end
        end
        for (int c = 0; c < 8; c++)
            div_check(3'(c));
        // a mid-run reset must bring back the reset values
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        outs(1'b1, 1'b1, 1'b0, 3'h0);
        rd(cpm_pkg::PowerCtrlAddr, 32'h03);
        tally_and_finish();
    end
endmodule
